// ===== design/bcd_consts.svh
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define APB_AW          8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WRAPS       8'h08

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_GATE_BIT   0
`define CTRL_RST        1'b1
`define ST_STATE_LSB    0
`define ST_TERM_BIT     4
`define ST_ASYNC_BIT    5
`define ST_ILLEGAL_BIT  6
`define WRAPS_W         16
`define WRAPS_RST       16'h0000
`define WRAPS_ONE       16'h0001
`define PINS_RST        9'h0C0

// ----------------------------------------------------------------
// counter codes
// ----------------------------------------------------------------
`define BCD_ZERO        4'h0
`define BCD_NINE        4'h9

`endif

// ===== design/bcd_pkg.sv
`include "bcd_consts.svh"

package bcd_pkg;

  // ----------------------------------------------------------------
  // pin group, sampled together through one synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       count_clock;
    logic       clear_n;
    logic       load_enable_n;
    logic       parallel_count_enable;
    logic       trickle_count_enable;
    logic [3:0] preset_inputs;
  } pin_bus_t;

  // mode after priority resolution, gray along clear-load-count-hold
  typedef enum logic [1:0] {
    OP_HOLD  = 2'b00,
    OP_COUNT = 2'b01,
    OP_LOAD  = 2'b11,
    OP_CLEAR = 2'b10
  } op_mode_t;

  // ----------------------------------------------------------------
  // next code when counting; illegal codes fold back within two steps
  // ----------------------------------------------------------------
  function automatic logic [3:0] bcd_inc(input logic [3:0] q);
    logic [3:0] n;
    n = 4'h0;
    case (q)
      `BCD_NINE: n = `BCD_ZERO;
      4'hA:      n = 4'hB;
      4'hB:      n = 4'h6;
      4'hC:      n = 4'hD;
      4'hD:      n = 4'h4;
      4'hE:      n = 4'hF;
      4'hF:      n = 4'h2;
      default:   n = 4'(q + 4'h1);
    endcase
    return n;
  endfunction : bcd_inc

  function automatic logic is_nine(input logic [3:0] q);
    return q == `BCD_NINE;
  endfunction : is_nine

endpackage : bcd_pkg

// ===== design/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser; first stage feeds only the second
module bit_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule : bit_sync

`default_nettype wire

// ===== design/rst_sync.sv
`timescale 1ns/10ps
`default_nettype none

// asserts at once, releases two clocks after rstn rises
module rst_sync (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      rst_n_out
);

  logic stage_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage_r   <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      stage_r   <= 1'b1;
      rst_n_out <= stage_r;
    end
  end

endmodule : rst_sync

`default_nettype wire

// ===== design/bcd_decade_counter.sv
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "bcd_consts.svh"

module bcd_decade_counter
  import bcd_pkg::*;
#(
  parameter bit ASYNC_CLEAR = 1'b1
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`APB_AW-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                count_clock,
  input  wire logic                clear_n,
  input  wire logic                load_enable_n,
  input  wire logic                parallel_count_enable,
  input  wire logic                trickle_count_enable,
  input  wire logic [3:0]          preset_inputs,
  output logic      [3:0]          count_state_outputs,
  output logic                     terminal_count
);

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic     rst_n_s;
  logic     state_rst_n;
  pin_bus_t pins_raw;
  pin_bus_t pins_s;

  rst_sync u_rst_sync (
    .clk       (clk),
    .rstn      (rstn),
    .rst_n_out (rst_n_s)
  );

  assign pins_raw = '{
    count_clock:           count_clock,
    clear_n:               clear_n,
    load_enable_n:         load_enable_n,
    parallel_count_enable: parallel_count_enable,
    trickle_count_enable:  trickle_count_enable,
    preset_inputs:         preset_inputs
  };

  bit_sync #(
    .W       ($bits(pin_bus_t)),
    .RST_VAL (`PINS_RST)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n_s),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // async variant: the raw pin clears the state flops without a clock;
  // a glitch on the pin clears too, as it would on the real part
  assign state_rst_n = ASYNC_CLEAR ? (rst_n_s & clear_n) : rst_n_s;

  // ----------------------------------------------------------------
  // count clock edge detect
  // ----------------------------------------------------------------
  logic cclk_d_r;
  logic cclk_d_nxt;
  logic cclk_edge;

  always_comb begin
    cclk_d_nxt = pins_s.count_clock;
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cclk_d_r <= 1'b0;
    end else begin
      cclk_d_r <= cclk_d_nxt;
    end
  end

  assign cclk_edge = pins_s.count_clock & ~cclk_d_r;

  // ----------------------------------------------------------------
  // mode resolution
  // ----------------------------------------------------------------
  logic     [0:0] ctrl_r;
  op_mode_t       mode;

  // in the async variant the synchronised clear keeps the state at zero
  // for two more clocks after release, so recovery never races an edge
  always_comb begin
    mode = OP_HOLD;
    if (!pins_s.clear_n) begin
      mode = OP_CLEAR;
    end else if (!pins_s.load_enable_n) begin
      mode = OP_LOAD;
    end else if (pins_s.parallel_count_enable && pins_s.trickle_count_enable
                 && ctrl_r[`CTRL_GATE_BIT]) begin
      mode = OP_COUNT;
    end
  end

  // ----------------------------------------------------------------
  // counter state and terminal count
  // ----------------------------------------------------------------
  logic [3:0] state_r;
  logic [3:0] state_nxt;
  logic       term_r;
  logic       term_nxt;

  always_comb begin
    state_nxt = state_r;
    if (cclk_edge) begin
      case (mode)
        OP_CLEAR: state_nxt = `BCD_ZERO;
        OP_LOAD:  state_nxt = pins_s.preset_inputs;
        OP_COUNT: state_nxt = bcd_inc(state_r);
        OP_HOLD:  state_nxt = state_r;
        default:  state_nxt = state_r;
      endcase
    end
    // registered from the next state, so the pin has no decode spikes
    term_nxt = pins_s.trickle_count_enable && is_nine(state_nxt);
  end

  always_ff @(posedge clk or negedge state_rst_n) begin
    if (!state_rst_n) begin
      state_r <= `BCD_ZERO;
      term_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      term_r  <= term_nxt;
    end
  end

  assign count_state_outputs = state_r;
  assign terminal_count      = term_r;

  // ----------------------------------------------------------------
  // apb slave: zero wait, answer registered at the setup edge
  // ----------------------------------------------------------------
  logic [0:0]          ctrl_nxt;
  logic [`WRAPS_W-1:0] wraps_r;
  logic [`WRAPS_W-1:0] wraps_nxt;
  logic [31:0]         prdata_nxt;
  logic                pready_nxt;
  logic                pslverr_nxt;
  logic                apb_setup;
  logic                apb_wr;
  logic                wrap_evt;
  logic                wraps_clr;

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign wrap_evt  = cclk_edge && (mode == OP_COUNT) && is_nine(state_r);
  assign wraps_clr = apb_wr && (paddr == `REG_WRAPS);

  always_comb begin
    ctrl_nxt    = ctrl_r;
    wraps_nxt   = wraps_r;
    prdata_nxt  = prdata;
    pready_nxt  = apb_setup;
    pslverr_nxt = 1'b0;
    if (apb_setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `REG_CTRL: begin
          prdata_nxt[`CTRL_GATE_BIT] = ctrl_r[0];
        end
        `REG_STATUS: begin
          prdata_nxt[`ST_STATE_LSB +: 4] = state_r;
          prdata_nxt[`ST_TERM_BIT]       = term_r;
          prdata_nxt[`ST_ASYNC_BIT]      = ASYNC_CLEAR;
          prdata_nxt[`ST_ILLEGAL_BIT]    = state_r > `BCD_NINE;
        end
        `REG_WRAPS: begin
          prdata_nxt[`WRAPS_W-1:0] = wraps_r;
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (apb_wr && (paddr == `REG_CTRL)) begin
      ctrl_nxt[0] = pwdata[`CTRL_GATE_BIT];
    end
    // a wrap in the clearing cycle is kept: set wins over clear
    if (wrap_evt) begin
      wraps_nxt = wraps_clr ? `WRAPS_ONE : `WRAPS_W'(wraps_r + `WRAPS_ONE);
    end else if (wraps_clr) begin
      wraps_nxt = `WRAPS_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_r  <= `CTRL_RST;
      wraps_r <= `WRAPS_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      wraps_r <= wraps_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_count_edge;
    cclk_edge && (mode == OP_COUNT);
  endsequence

  sequence s_load_edge;
    cclk_edge && pins_s.clear_n && !pins_s.load_enable_n;
  endsequence

  a_nine_wraps_zero:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      s_count_edge ##0 (state_r == `BCD_NINE) |=> (state_r == `BCD_ZERO))
    else $error("count from nine did not reach zero");

  a_count_steps_one:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      s_count_edge ##0 (state_r < `BCD_NINE) |=>
        (state_r == 4'($past(state_r) + 4'h1)))
    else $error("legal count did not step by one");

  a_no_edge_stable:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      !cclk_edge |=> $stable(state_r))
    else $error("state moved without a count clock edge");

  a_clear_beats_load:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      cclk_edge && !pins_s.clear_n |=> (state_r == `BCD_ZERO) && !terminal_count)
    else $error("clear did not zero the state");

  a_async_clear_low:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      ASYNC_CLEAR && !clear_n |-> (state_r == `BCD_ZERO))
    else $error("async clear did not hold state low");

  a_load_copies_in:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      s_load_edge |=> (state_r == $past(pins_s.preset_inputs)))
    else $error("load did not copy the preset inputs");

  a_enable_low_hold:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      cclk_edge && pins_s.clear_n && pins_s.load_enable_n &&
      !(pins_s.parallel_count_enable && pins_s.trickle_count_enable)
        |=> $stable(state_r))
    else $error("state changed with a count enable low");

  a_term_decode:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      1'b1 |=> terminal_count ==
        ($past(pins_s.trickle_count_enable) && (state_r == `BCD_NINE)))
    else $error("terminal count does not match its decode");

  a_term_only_nine:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      terminal_count |-> (state_r == `BCD_NINE))
    else $error("terminal count high outside state nine");

  // even illegal codes may step to an odd one, which must fold back next
  a_illegal_recover:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      s_count_edge ##0 (state_r > `BCD_NINE) |=>
        (state_r <= `BCD_NINE) || (state_r[0] && !$past(state_r[0])))
    else $error("illegal code not moving toward the decimal sequence");

  a_illegal_odd_fold:
    assert property (@(posedge clk) disable iff (!state_rst_n)
      s_count_edge ##0 (state_r > `BCD_NINE) ##0 state_r[0] |=>
        (state_r <= `BCD_NINE))
    else $error("odd illegal code not folded into a legal code");

  a_apb_zero_wait:
    assert property (@(posedge clk) disable iff (!rst_n_s)
      psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not in the first access cycle");

endmodule : bcd_decade_counter

`default_nettype wire

// ===== tb/pin_driver.sv
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------
// far side: control logic driving the counter pins
// --------------------------------------------------------------
// terminal_count is never fed back here as a clock or a clear
module pin_driver
  import bcd_pkg::*;
(
  input  wire logic clk,
  output var  pin_bus_t pins
);
  initial pins = pin_bus_t'({1'b0, 4'hC, 4'h0});

  // count clock idles low; controls settle 3 clocks before the rise
  task automatic step(input logic [3:0] c, input logic [3:0] pre);
    @(posedge clk);
    pins <= pin_bus_t'({1'b0, c, pre});
    repeat (3) @(posedge clk);
    pins.count_clock <= 1'b1;
    repeat (3) @(posedge clk);
    pins.count_clock <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : step

  task automatic set_clear(input logic v);
    @(posedge clk);
    pins.clear_n <= v;
  endtask : set_clear
endmodule : pin_driver
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb
  import bcd_pkg::*;
;
  typedef struct packed {
    logic [3:0] c;
    logic [3:0] pre;
    logic [4:0] exp;
  } row_t;

  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  q;
  logic        tc;
  logic [3:0]  q_s;
  logic        tc_s;
  pin_bus_t    pins;
  row_t        rows [14];
  int          failures;
  int          total_checks;
  logic [31:0] r;
  logic        e;

  pin_driver i_far (.clk(clk), .pins(pins));

  bcd_decade_counter i_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_clock(pins.count_clock), .clear_n(pins.clear_n),
    .load_enable_n(pins.load_enable_n),
    .parallel_count_enable(pins.parallel_count_enable),
    .trickle_count_enable(pins.trickle_count_enable),
    .preset_inputs(pins.preset_inputs), .count_state_outputs(q),
    .terminal_count(tc)
  );

  // second copy built as the synchronous-clear variant, same pins and bus
  bcd_decade_counter #(.ASYNC_CLEAR(1'b0)) i_dut_sync (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(),
    .pslverr(), .count_clock(pins.count_clock), .clear_n(pins.clear_n),
    .load_enable_n(pins.load_enable_n),
    .parallel_count_enable(pins.parallel_count_enable),
    .trickle_count_enable(pins.trickle_count_enable),
    .preset_inputs(pins.preset_inputs), .count_state_outputs(q_s),
    .terminal_count(tc_s)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk_pin(input string n, input logic [4:0] x, input logic [4:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask : chk_pin

  task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask : chk_reg

  // entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stalled wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg("prdata", x, r);
    chk_reg("pslverr", 32'h0000_0000, {31'h0000_0000, e});
  endtask : rd

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #600000;
    failures++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    failures = 0;
    total_checks = 0;
    rows = '{'{4'h9, 4'h8, 5'h08}, '{4'hF, 4'h0, 5'h19}, '{4'hD, 4'h0, 5'h19},
             '{4'hE, 4'h0, 5'h09}, '{4'hF, 4'h0, 5'h00}, '{4'hB, 4'h5, 5'h05},
             '{4'hF, 4'h0, 5'h06}, '{4'h3, 4'h7, 5'h00}, '{4'h9, 4'hA, 5'h0A},
             '{4'hF, 4'h0, 5'h0B}, '{4'hF, 4'h0, 5'h06}, '{4'h9, 4'hF, 5'h0F},
             '{4'hF, 4'h0, 5'h02}, '{4'h9, 4'h9, 5'h19}};
    repeat (6) @(posedge clk);
    chk_pin("reset pins", 5'h00, {tc, q});
    chk_reg("reset prdata", 32'h0000_0000, prdata);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h0000_0001);
    rd(8'h04, 32'h0000_0020);
    rd(8'h08, 32'h0000_0000);
    $display("test reset done");
    // load, count, hold, wrap, priority, illegal codes
    foreach (rows[i]) begin
      i_far.step(rows[i].c, rows[i].pre);
      chk_pin("row state", rows[i].exp, {tc, q});
      chk_pin("row state sync", rows[i].exp, {tc_s, q_s});
    end
    $display("test rows done");
    rd(8'h04, 32'h0000_0039);
    rd(8'h08, 32'h0000_0001);
    i_far.set_clear(1'b0);
    #2;
    chk_pin("async clear", 5'h00, {tc, q});
    chk_pin("sync clear waits", 5'h19, {tc_s, q_s});
    i_far.step(4'h7, 4'h0);
    chk_pin("async clear held", 5'h00, {tc, q});
    chk_pin("sync clear edge", 5'h00, {tc_s, q_s});
    i_far.set_clear(1'b1);
    repeat (4) @(posedge clk);
    for (int i = 1; i <= 10; i++) begin
      i_far.step(4'hF, 4'h0);
      chk_pin("decade", {(i == 9), 4'(i % 10)}, {tc, q});
      chk_pin("decade sync", {(i == 9), 4'(i % 10)}, {tc_s, q_s});
    end
    rd(8'h08, 32'h0000_0002);
    $display("test decade done");
    apb(1'b1, 8'h00, 32'h0000_0000);
    i_far.step(4'hF, 4'h0);
    chk_pin("gated hold", 5'h00, {tc, q});
    apb(1'b1, 8'h00, 32'h0000_0001);
    i_far.step(4'hF, 4'h0);
    chk_pin("gated count", 5'h01, {tc, q});
    apb(1'b1, 8'h04, 32'h0000_00FF);
    rd(8'h04, 32'h0000_0021);
    apb(1'b1, 8'h08, 32'h0000_1234);
    rd(8'h08, 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk_reg("unmapped prdata", 32'h0000_0000, r);
    chk_reg("unmapped pslverr", 32'h0000_0001, {31'h0000_0000, e});
    i_far.step(4'h9, 4'hC);
    rd(8'h04, 32'h0000_006C);
    $display("test registers done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
